/* design/input_filter.v */
// two-flop synchroniser followed by an integrating noise filter
`timescale 1ns/100ps
`include "tape_sender_map.vh"
module input_filter #(
  parameter [31:0] FILT_CYCLES = 32'd10000
) (
  clk,
  reset,
  raw,
  level
);
  input wire clk;
  input wire reset;
  input wire raw;
  output reg level;

  reg sync1_r;
  reg sync2_r;
  reg [31:0] integ_r;

  // ==========================================
  // synchroniser: sync1_r is read only by sync2_r
  always @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================
  // integrator: output follows only a level that persists for the full count
  always @(posedge clk) begin
    if (reset) begin
      integ_r <= `TS_ZERO32;
      level <= 1'b0;
    end else if (sync2_r != level) begin
      if (integ_r >= FILT_CYCLES - `TS_ONE32) begin
        integ_r <= `TS_ZERO32;
        level <= sync2_r;
      end else begin
        integ_r <= integ_r + `TS_ONE32;
      end
    end else begin
      integ_r <= `TS_ZERO32;
    end
  end
endmodule // input_filter

/* design/oneshot_timer.v */
// retriggerable one-shot with a pulse on its trailing edge
`timescale 1ns/100ps
`include "tape_sender_map.vh"
module oneshot_timer #(
  parameter [31:0] LEN = 32'd1
) (
  clk,
  reset,
  trig,
  active,
  trail
);
  input wire clk;
  input wire reset;
  input wire trig;
  output reg active;
  output reg trail;

  reg [31:0] cnt_r;

  // ==========================================
  // active stands LEN cycles from the edge after trig
  always @(posedge clk) begin
    if (reset) begin
      cnt_r <= `TS_ZERO32;
      active <= 1'b0;
      trail <= 1'b0;
    end else begin
      trail <= 1'b0;
      if (trig) begin
        cnt_r <= LEN - `TS_ONE32;
        active <= 1'b1;
      end else if (active) begin
        if (cnt_r == `TS_ZERO32) begin
          active <= 1'b0;
          trail <= 1'b1;
        end else begin
          cnt_r <= cnt_r - `TS_ONE32;
        end
      end
    end
  end
endmodule // oneshot_timer

/* design/tape_sender.v */
// start-stop serial sender: tape character in, 10-bit frame out
//
// Overview of operation
// - about 300 ms after power-up one reset pulse forces the output element to mark.
// - each character timing pulse halts the bit oscillator and starts the stop interval.
// - the stop timer lasts one stop pulse and its trailing edge restarts the oscillator.
// - the restart passes only while the tape-present contact is closed, else the line idles at mark.
// - the end of the stop pulse starts a half-bit sample delay before the code is loaded.
// - at the sample pulse each hole level sets its element to 1 and each blank leaves it at 0.
// - during the sample delay the first oscillator pulse clears the register and advances are blocked.
// - after the sample delay no clear pulses occur and every oscillator pulse is an advance.
// - the clear pulse drives the output element from 1 to 0 as the start space, then the load follows.
// - each advance shifts the whole code one place toward the output element.
// - the shift input is held at 1 so ones fill in behind the code.
// - after the last code bit the output element sits at 1 as stop until the next clear.
// - the mark and tape-present contacts are filtered before they are sampled.
// - request-to-send follows the motor switch, or is held on in the fixed-on variant.
// - each character is a 10-bit frame at 1050 baud.
// - five or up to eight levels; unused level 0 goes as space, unused levels 6 and 7 as mark.
`timescale 1ns/100ps
`include "tape_sender_map.vh"
module tape_sender #(
  parameter [31:0] POR_CYCLES =
    `TS_POR_MS * (`TS_CLK_HZ / 1000),
  parameter [31:0] BIT_CYCLES =
    `TS_CLK_HZ / `TS_BAUD,
  parameter [31:0] SIG_DELAY_CYCLES =
    `TS_SIG_DELAY_US * (`TS_CLK_HZ / 1000000),
  parameter [31:0] FILT_CYCLES =
    `TS_FILTER_US * (`TS_CLK_HZ / 1000000)
) (
  clk,
  reset,
  char_pulse,
  tape_mark,
  tape_present,
  motor_switch,
  rts_fixed_on,
  use_level0,
  use_level6,
  use_level7,
  line_out,
  rts,
  sample_pulse
);
  input wire clk;
  input wire reset;
  input wire char_pulse;
  input wire [7:0] tape_mark;
  input wire tape_present;
  input wire motor_switch;
  input wire rts_fixed_on;
  input wire use_level0;
  input wire use_level6;
  input wire use_level7;
  output reg line_out;
  output reg rts;
  output reg sample_pulse;

  // ==========================================
  // derived timing
  // stop timer spans the stop element; sample delay is half a bit (rounded down, but at least one cycle)
  localparam [31:0] STOP_CYCLES = BIT_CYCLES * `TS_STOP_BITS;
  localparam [31:0] HALF_CYCLES = BIT_CYCLES / 32'd2;
  localparam [31:0] SAMPLE_CYCLES =
    (HALF_CYCLES == `TS_ZERO32) ? `TS_ONE32 : HALF_CYCLES;
  // documentation only: start + 8 levels + stop
  localparam [31:0] FRAME_BITS = `TS_FRAME_BITS;

  // ==========================================
  // declarations
  reg [31:0] por_cnt_r;
  reg por_done_r;
  reg por_pulse_r;
  reg cp_s1_r;
  reg cp_s2_r;
  reg cp_prev_r;
  reg ms_s1_r;
  reg ms_s2_r;
  reg fx_s1_r;
  reg fx_s2_r;
  reg osc_run_r;
  reg osc_run_nxt;
  reg [31:0] osc_cnt_r;
  reg osc_pulse_r;
  reg [7:0] code_r;
  reg [7:0] load_mask;
  reg [7:0] load_val;
  wire [7:0] mark_filt;
  wire present_filt;
  wire cp_edge;
  wire sig_trail;
  wire stop_trail;
  wire [8:0] shift_src;
  wire restart;
  wire samp_active;
  wire samp_trail;
  wire clear_pulse;
  wire advance_pulse;

  // ==========================================
  // power-on reset pulse
  // fires once, POR_CYCLES after reset releases, as a power-up stand-in
  always @(posedge clk) begin
    if (reset) begin
      por_cnt_r <= `TS_ZERO32;
      por_done_r <= 1'b0;
      por_pulse_r <= 1'b0;
    end else begin
      por_pulse_r <= 1'b0;
      if (!por_done_r) begin
        if (por_cnt_r >= POR_CYCLES - `TS_ONE32) begin
          por_done_r <= 1'b1;
          por_pulse_r <= 1'b1;
        end else begin
          por_cnt_r <= por_cnt_r + `TS_ONE32;
        end
      end
    end
  end

  // ==========================================
  // contact filters
  // mechanical contacts bounce; only the integrated level is ever sampled
  genvar gi;
  generate
    for (gi = 0; gi < `TS_CODE_LEVELS; gi = gi + 1) begin : g_mark
      input_filter #(
        .FILT_CYCLES(FILT_CYCLES)
      ) u_mark_filt (
        .clk(clk),
        .reset(reset),
        .raw(tape_mark[gi]),
        .level(mark_filt[gi])
      );
    end
  endgenerate

  input_filter #(
    .FILT_CYCLES(FILT_CYCLES)
  ) u_present_filt (
    .clk(clk),
    .reset(reset),
    .raw(tape_present),
    .level(present_filt)
  );

  // ==========================================
  // synchronisers for the timing pulse and the switches
  always @(posedge clk) begin
    if (reset) begin
      cp_s1_r <= 1'b0;
      cp_s2_r <= 1'b0;
      cp_prev_r <= 1'b0;
      ms_s1_r <= 1'b0;
      ms_s2_r <= 1'b0;
      fx_s1_r <= 1'b0;
      fx_s2_r <= 1'b0;
    end else begin
      cp_s1_r <= char_pulse;
      cp_s2_r <= cp_s1_r;
      cp_prev_r <= cp_s2_r;
      ms_s1_r <= motor_switch;
      ms_s2_r <= ms_s1_r;
      fx_s1_r <= rts_fixed_on;
      fx_s2_r <= fx_s1_r;
    end
  end

  assign cp_edge = cp_s2_r & ~cp_prev_r;

  // ==========================================
  // signal delay: the pickup pulse acts a short while after it arrives
  oneshot_timer #(
    .LEN(SIG_DELAY_CYCLES)
  ) u_sig_delay (
    .clk(clk),
    .reset(reset),
    .trig(cp_edge),
    .active(),
    .trail(sig_trail)
  );

  // ==========================================
  // stop timer
  oneshot_timer #(
    .LEN(STOP_CYCLES)
  ) u_stop_timer (
    .clk(clk),
    .reset(reset),
    .trig(sig_trail),
    .active(),
    .trail(stop_trail)
  );

  // start pulse gate: without tape the oscillator stays halted
  assign restart = stop_trail & present_filt;

  // ==========================================
  // oscillator control flip-flop
  // a halt beats a restart landing in the same cycle
  always @* begin
    osc_run_nxt = osc_run_r;
    if (restart) begin
      osc_run_nxt = 1'b1;
    end
    if (sig_trail) begin
      osc_run_nxt = 1'b0;
    end
  end

  // ==========================================
  // gated start-stop oscillator
  // phase is reloaded at each restart, so rate error never accumulates
  always @(posedge clk) begin
    if (reset) begin
      osc_run_r <= 1'b0;
      osc_cnt_r <= `TS_ZERO32;
      osc_pulse_r <= 1'b0;
    end else begin
      osc_run_r <= osc_run_nxt;
      osc_pulse_r <= 1'b0;
      if (restart) begin
        osc_cnt_r <= `TS_ZERO32;
        osc_pulse_r <= 1'b1;
      end else if (osc_run_r && !sig_trail) begin
        if (osc_cnt_r >= BIT_CYCLES - `TS_ONE32) begin
          osc_cnt_r <= `TS_ZERO32;
          osc_pulse_r <= 1'b1;
        end else begin
          osc_cnt_r <= osc_cnt_r + `TS_ONE32;
        end
      end
    end
  end

  // ==========================================
  // sample delay
  oneshot_timer #(
    .LEN(SAMPLE_CYCLES)
  ) u_sample_delay (
    .clk(clk),
    .reset(reset),
    .trig(restart),
    .active(samp_active),
    .trail(samp_trail)
  );

  // ==========================================
  // pulse control gate
  assign clear_pulse = osc_pulse_r & samp_active;
  assign advance_pulse = osc_pulse_r & ~samp_active;

  // ==========================================
  // load pattern
  // levels that are not in use are forced: level 0 to space, 6 and 7 to mark
  always @* begin
    load_mask = {8{1'b1}};
    load_val = mark_filt;
    if (!use_level0) begin
      load_val[`TS_LVL0] = `TS_SPACE;
    end
    if (!use_level6) begin
      load_val[`TS_LVL6] = `TS_MARK;
    end
    if (!use_level7) begin
      load_val[`TS_LVL7] = `TS_MARK;
    end
  end

  // ==========================================
  // code register, level 0 nearest the output element
  // the top element shifts in a constant mark so ones fill behind the code
  assign shift_src = {`TS_MARK, code_r};
  generate
    for (gi = 0; gi < `TS_CODE_LEVELS; gi = gi + 1) begin : g_reg
      always @(posedge clk) begin
        if (reset) begin
          code_r[gi] <= `TS_MARK;
        end else if (clear_pulse) begin
          code_r[gi] <= `TS_SPACE;
        end else if (samp_trail) begin
          code_r[gi] <= load_val[gi] & load_mask[gi];
        end else if (advance_pulse) begin
          code_r[gi] <= shift_src[gi + 1];
        end
      end
    end
  endgenerate

  // ==========================================
  // output element drives the line directly
  // once the code has passed, ones shifted in leave it at mark
  always @(posedge clk) begin
    if (reset) begin
      line_out <= `TS_MARK;
    end else if (por_pulse_r) begin
      line_out <= `TS_MARK;
    end else if (clear_pulse) begin
      line_out <= `TS_SPACE;
    end else if (advance_pulse) begin
      line_out <= code_r[`TS_LVL0];
    end
  end

  // ==========================================
  // sample lead and request-to-send
  always @(posedge clk) begin
    if (reset) begin
      sample_pulse <= 1'b0;
      rts <= 1'b0;
    end else begin
      sample_pulse <= samp_trail;
      rts <= ms_s2_r | fx_s2_r;
    end
  end
endmodule // tape_sender

/* include/tape_sender_map.vh */
// timing constants and level positions for the tape start-stop sender
`ifndef TAPE_SENDER_MAP_VH
`define TAPE_SENDER_MAP_VH

// ==========================================
// clock
`define TS_CLK_NS 10
`define TS_CLK_HZ 100000000

// ==========================================
// line rate and frame
`define TS_BAUD 1050
`define TS_FRAME_BITS 10
`define TS_CODE_LEVELS 8
`define TS_FIXED_LEVELS 5

// ==========================================
// times, in their own units
`define TS_POR_MS 300
`define TS_SIG_DELAY_US 50
`define TS_FILTER_US 100
`define TS_STOP_BITS 1

// ==========================================
// level positions inside the code register
`define TS_LVL0 0
`define TS_LVL6 6
`define TS_LVL7 7
`define TS_TOP_LVL 7

// ==========================================
// levels and reset values
`define TS_MARK 1'h1
`define TS_SPACE 1'h0
`define TS_REG_IDLE 8'hFF
`define TS_ONE32 32'h1
`define TS_ZERO32 32'h0

`endif

/* tb/reader_model.sv */
// paper tape reader stand-in: timing pulse, mark contacts, tape-present
`timescale 1ns/100ps
module reader_model (
  input wire logic clk,
  output logic char_pulse,
  output logic [7:0] tape_mark,
  output logic tape_present
);
  // ==========================================
  // contact drivers
  initial begin
    char_pulse = 1'h0;
    tape_mark = 8'h00;
    tape_present = 1'h0;
  end
  // contacts settle well before the pulse so the filters have passed them
  task automatic read_char(input logic [7:0] code, input logic present);
    @(posedge clk);
    tape_mark <= present ? code : 8'h00;
    tape_present <= present;
    repeat (10) @(posedge clk);
    char_pulse <= 1'h1;
    repeat (4) @(posedge clk);
    char_pulse <= 1'h0;
  endtask
  // contact bounce shorter than the filter span
  task automatic bounce(input logic [7:0] which);
    @(posedge clk);
    tape_mark <= tape_mark ^ which;
    repeat (2) @(posedge clk);
    tape_mark <= tape_mark ^ which;
  endtask
endmodule // reader_model

/* tb/tape_sender_props.sv */
// port-level assertions for the tape start-stop sender
`timescale 1ns/100ps
module tape_sender_props #(
  parameter [31:0] BIT_CYCLES = 32'h17406,
  parameter [31:0] SIG_DELAY_CYCLES = 32'h1388
) (
  input wire clk,
  input wire reset,
  input wire char_pulse,
  input wire tape_present,
  input wire motor_switch,
  input wire rts_fixed_on,
  input wire line_out,
  input wire rts,
  input wire sample_pulse
);
  // ==========================================
  // frame and pulse age counters
  localparam [31:0] SAT = 32'hFFFFFFFF;
  logic prev_r;
  logic [31:0] since_r;
  logic [31:0] age_r;
  logic [31:0] frame_r;
  wire fall_now = prev_r & ~line_out;
  wire [31:0] since = fall_now ? 32'h0 : since_r;
  // a fall a full frame after the last start is a start bit, not a space data bit
  wire start_now = fall_now && frame_r >= 32'hA * BIT_CYCLES;
  wire rts_req = motor_switch | rts_fixed_on;
  always @(posedge clk) begin
    prev_r <= reset ? 1'h1 : line_out;
    if (reset || $rose(char_pulse)) begin
      age_r <= reset ? SAT : 32'h1;
    end else if (age_r != SAT) begin
      age_r <= age_r + 32'h1;
    end
    if (reset) begin
      since_r <= SAT;
    end else if (fall_now || since_r != SAT) begin
      since_r <= since + 32'h1;
    end
    if (reset) begin
      frame_r <= SAT;
    end else if (start_now) begin
      frame_r <= 32'h1;
    end else if (frame_r != SAT) begin
      frame_r <= frame_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // properties
  property p_rst_idle;
    disable iff (1'h0) reset |=> line_out && !rts && !sample_pulse;
  endproperty
  property p_start_hold;
    since < BIT_CYCLES |-> !line_out;
  endproperty
  property p_sample_time;
    sample_pulse |-> since == BIT_CYCLES / 32'h2;
  endproperty
  property p_bit_grid;
    $changed(line_out) && since < 32'hA * BIT_CYCLES |-> since % BIT_CYCLES == 32'h0;
  endproperty
  property p_stop_hold;
    since >= 32'h9 * BIT_CYCLES |-> line_out;
  endproperty
  property p_rts_on;
    rts_req [*4] |=> rts;
  endproperty
  property p_rts_off;
    !rts_req [*4] |=> !rts;
  endproperty
  property p_no_tape;
    !tape_present [*8] |-> ##4 !start_now;
  endproperty
  property p_start_cause;
    start_now |-> age_r >= BIT_CYCLES && age_r <= BIT_CYCLES + SIG_DELAY_CYCLES + 32'h8;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  a_start_hold: assert property (p_start_hold) else $error("start space too short");
  a_sample_time: assert property (p_sample_time) else $error("sample pulse off half bit");
  a_bit_grid: assert property (p_bit_grid) else $error("line change off bit grid");
  a_stop_hold: assert property (p_stop_hold) else $error("stop mark not held");
  a_rts_on: assert property (p_rts_on) else $error("rts not raised");
  a_rts_off: assert property (p_rts_off) else $error("rts not dropped");
  a_no_tape: assert property (p_no_tape) else $error("start without tape");
  a_start_cause: assert property (p_start_cause) else $error("start not one stop after pulse");
  c_frame: cover property (start_now);
  c_sample: cover property (sample_pulse);
  c_rts: cover property ($rose(rts));
endmodule // tape_sender_props

bind tape_sender tape_sender_props #(.BIT_CYCLES(BIT_CYCLES), .SIG_DELAY_CYCLES(SIG_DELAY_CYCLES)) props (
  .clk(clk),
  .reset(reset),
  .char_pulse(char_pulse),
  .tape_present(tape_present),
  .motor_switch(motor_switch),
  .rts_fixed_on(rts_fixed_on),
  .line_out(line_out),
  .rts(rts),
  .sample_pulse(sample_pulse)
);

/* tb/tape_sender_test.sv */
// self-checking bench for the tape start-stop sender
`timescale 1ns/100ps
module tape_sender_test;
  localparam [31:0] BIT = 32'h28;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic motor_switch = 1'h0;
  logic rts_fixed_on = 1'h0;
  logic use_level0 = 1'h0;
  logic use_level6 = 1'h0;
  logic use_level7 = 1'h0;
  wire char_pulse;
  wire [7:0] tape_mark;
  wire tape_present;
  wire line_out;
  wire rts;
  wire sample_pulse;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  reader_model rd (.clk(clk), .char_pulse(char_pulse), .tape_mark(tape_mark), .tape_present(tape_present));
  // short counts keep the run brief
  tape_sender #(.POR_CYCLES(32'h14), .BIT_CYCLES(BIT), .SIG_DELAY_CYCLES(32'h3), .FILT_CYCLES(32'h4)) uut (
    .clk(clk),
    .reset(reset),
    .char_pulse(char_pulse),
    .tape_mark(tape_mark),
    .tape_present(tape_present),
    .motor_switch(motor_switch),
    .rts_fixed_on(rts_fixed_on),
    .use_level0(use_level0),
    .use_level6(use_level6),
    .use_level7(use_level7),
    .line_out(line_out),
    .rts(rts),
    .sample_pulse(sample_pulse)
  );
  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // used bits: 0 level0, 1 level6, 2 level7
  task automatic frame(input logic [7:0] code, input logic [2:0] used, input logic present);
    logic [8:0] exp;
    int n;
    int at;
    @(posedge clk);
    use_level0 <= used[0];
    use_level6 <= used[1];
    use_level7 <= used[2];
    exp = {1'h1, used[2] ? code[7] : 1'h1, used[1] ? code[6] : 1'h1, code[5:1], used[0] & code[0]};
    rd.read_char(code, present);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (line_out !== 1'h0 && n < 200);
    check(line_out === 1'h0, present, "frame start");
    if (line_out === 1'h0) begin
      n = 0;
      at = 0;
      fork
        begin
          repeat (17) @(posedge clk);
          rd.bounce(8'h08);
        end
        for (int i = 1; i <= 9 * BIT; i++) begin
          @(negedge clk);
          if (sample_pulse === 1'h1) begin
            n++;
            at = i;
          end
          if (i % BIT == 0) check(line_out, exp[i / BIT - 1], "line bit");
        end
      join
      check(n, 1, "sample pulses");
      check(at, BIT / 2, "sample time");
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset_idle;
    @(negedge clk);
    check({line_out, rts, sample_pulse}, 3'h4, "idle after reset");
    repeat (30) @(negedge clk);
    check(line_out, 1'h1, "after power-on pulse");
  endtask
  task automatic t_rts;
    @(posedge clk);
    motor_switch <= 1'h1;
    repeat (6) @(negedge clk);
    check(rts, 1'h1, "rts motor on");
    @(posedge clk);
    motor_switch <= 1'h0;
    repeat (6) @(negedge clk);
    check(rts, 1'h0, "rts motor off");
    @(posedge clk);
    rts_fixed_on <= 1'h1;
    repeat (6) @(negedge clk);
    check(rts, 1'h1, "rts strap");
  endtask
  task automatic t_eight_level;
    frame(8'hA5, 3'h7, 1'h1);
    frame(8'h5A, 3'h7, 1'h1);
    frame(8'h00, 3'h7, 1'h1);
  endtask
  task automatic t_no_tape;
    frame(8'h3C, 3'h7, 1'h0);
  endtask
  task automatic t_five_level;
    frame(8'h41, 3'h0, 1'h1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    t_reset_idle();
    t_rts();
    t_eight_level();
    t_no_tape();
    t_five_level();
    tally_and_finish();
  end
endmodule // tape_sender_test
